// ### ifss_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package ifss_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RETRY_UNIT_MS = 16'h000a;
  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_WARN      = 8'h57;
  localparam logic [7:0] CMD_UV_WARN      = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT     = 8'h59;
  localparam logic [7:0] CMD_UV_ACTION    = 8'h5a;
  localparam logic [7:0] CMD_PG_ON        = 8'h5e;
  localparam logic [7:0] CMD_TURN_ON_DELAY_TIME    = 8'h60;
  localparam logic [7:0] CMD_TON_RAMP     = 8'h61;
  localparam logic [7:0] CMD_TURN_OFF_DELAY_TIME   = 8'h64;
  localparam logic [7:0] CMD_TOFF_RAMP    = 8'h65;
  localparam logic [7:0] CMD_SUMMARY      = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
  // Reset values
  localparam logic [15:0] RST_OV_WARN  = 16'hd34d;
  localparam logic [15:0] RST_UV_WARN  = 16'hca30;
  localparam logic [15:0] RST_UV_FAULT = 16'hca00;
  localparam logic [7:0]  RST_ACTION   = 8'h80;
  localparam logic [15:0] RST_DELAY    = 16'hca80;
  localparam logic [15:0] RST_RAMP     = 16'hd280;
  // Fault action fields and codes
  localparam int RESP_HI = 7, RESP_LO = 6, RETRY_HI = 5, RETRY_LO = 3, TIME_HI = 2, TIME_LO = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0, RESP_DELAY = 2'h1, RESP_NOW = 2'h2, RESP_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0, RETRY_FOREVER = 3'h7;
  // Summary and status word bits, power-good ratio
  localparam int SB_BUSY = 7, SB_OFF = 6, SB_VOUT_OV = 5, SB_IOUT_OC = 4;
  localparam int SB_VIN_UV = 3, SB_TEMP = 2, SB_CML = 1, SB_UNLISTED = 0;
  localparam int SW_INPUT = 13, SW_PG_N = 11;
  localparam int PG_NUM = 9, PG_DEN = 10;

  typedef enum logic [3:0] {
    S_OFF, S_ON_DELAY, S_RISING, S_ON, S_OFF_DELAY, S_FALLING,
    S_FAULT_DELAY, S_RETRY_WAIT, S_HOLD_OFF, S_LATCHED
  } ifss_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } ifss_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] data;
  } ifss_rsp_t;

  typedef struct packed {
    ifss_state_t state;
    logic [17:0] pre;
    logic [15:0] msCnt;
    logic [15:0] ovWarnLim;
    logic [15:0] uvWarnLim;
    logic [15:0] uvFaultLim;
    logic [7:0]  uvAction;
    logic [15:0] pgOn;
    logic [15:0] tonDly;
    logic [15:0] tonRamp;
    logic [15:0] toffDly;
    logic [15:0] toffRamp;
    logic        strapDone;
    logic [2:0]  retriesLeft;
    logic        uvActive;
    logic [7:0]  flags;
    logic [1:0]  inWarn;
    logic        railOn;
    logic        rampUp;
    logic        rampDown;
    logic        powerGood;
    logic        alert;
    ifss_rsp_t   rsp;
  } ifss_st_t;
endpackage

// ### ifss_top.sv
`timescale 1ns/10ps
module ifss_top import ifss_pkg::*; #(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Command port
  input  wire ifss_cmd_t   cmd,
  output ifss_rsp_t        rsp,
  // Measurements and strap
  input  wire logic [15:0] vinMeas,
  input  wire logic [15:0] voutMeas,
  input  wire logic [15:0] outUvFaultThreshold,
  input  wire logic [15:0] voutStrap,
  // Enable and other fault sources
  input  wire logic        runEnable,
  input  wire logic        busyFault,
  input  wire logic        voutOvFault,
  input  wire logic        ioutOcFault,
  input  wire logic        tempFault,
  input  wire logic        cmlFault,
  // Rail control and status
  output logic             railOn,
  output logic             rampUp,
  output logic             rampDown,
  output logic             powerGood,
  output logic             alert
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Linear 11-bit word to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11ToFix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m  = 48'(signed'(w[10:0]));
    sh = {w[15], w[15:11]} + 6'h10;
    return m <<< sh;
  endfunction

  // Linear 11-bit time in ms to whole ms, saturated
  function automatic logic [15:0] l11ToMs(input logic [15:0] w);
    logic signed [47:0] f;
    f = l11ToFix(w);
    if (f < 0) return 16'h0000;
    if (f[47:32] != 16'h0000) return 16'hffff;
    return f[31:16];
  endfunction

  // Critical fault summary byte
  function automatic logic [7:0] summaryOf(input ifss_st_t s);
    logic [7:0] b;
    b = s.flags;
    b[SB_OFF] = !s.railOn;
    return b;
  endfunction

  ifss_st_t           st_q, st_d;
  logic               tick, clr, trig, resumeOk;
  logic signed [47:0] vinF;
  logic               ovEvt, uvwEvt, uvfEvt;
  logic [7:0]         evt, kept;
  logic [1:0]         respCode;
  logic [2:0]         retryCfg;
  logic [15:0]        retryMs, stWord;
  ifss_state_t        afterOff;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.rsp.valid = 1'b0;
    st_d.rsp.error = 1'b0;
    // Millisecond prescaler
    tick = (st_q.pre == 18'(MS_CYCLES_P - 1));
    st_d.pre = tick ? 18'h0 : st_q.pre + 18'h1;
    // Power-good threshold defaults to nine tenths of the strap
    if (!st_q.strapDone) begin
      st_d.pgOn = 16'((32'(voutStrap) * PG_NUM) / PG_DEN);
      st_d.strapDone = 1'b1;
    end
    // Input voltage comparisons
    vinF   = l11ToFix(vinMeas);
    ovEvt  = vinF > l11ToFix(st_q.ovWarnLim);
    uvwEvt = vinF < l11ToFix(st_q.uvWarnLim);
    uvfEvt = vinF < l11ToFix(st_q.uvFaultLim);
    // Fault with hysteresis up to the warning limit
    if (uvfEvt) begin
      st_d.uvActive = 1'b1;
    end else if (vinF > l11ToFix(st_q.uvWarnLim)) begin
      st_d.uvActive = 1'b0;
    end
    // Event vector in summary layout
    evt = 8'h00;
    evt[SB_BUSY]     = busyFault;
    evt[SB_VOUT_OV]  = voutOvFault;
    evt[SB_IOUT_OC]  = ioutOcFault;
    evt[SB_VIN_UV]   = uvfEvt;
    evt[SB_TEMP]     = tempFault;
    evt[SB_CML]      = cmlFault;
    evt[SB_UNLISTED] = ovEvt | uvwEvt;
    stWord = 16'h0000;
    stWord[7:0] = summaryOf(st_q);
    stWord[SW_INPUT] = st_q.flags[SB_VIN_UV] | (|st_q.inWarn);
    stWord[SW_PG_N]  = !st_q.powerGood;
    // Command port
    clr = 1'b0;
    if (cmd.valid) begin
      st_d.rsp.valid = 1'b1;
      st_d.rsp.data  = 16'h0000;
      if (cmd.write) begin
        case (cmd.code)
          CMD_CLEAR_FAULTS: clr = 1'b1;
          CMD_OV_WARN:      st_d.ovWarnLim = cmd.data;
          CMD_UV_WARN:      st_d.uvWarnLim = cmd.data;
          CMD_UV_FAULT:     st_d.uvFaultLim = cmd.data;
          CMD_UV_ACTION:    st_d.uvAction = cmd.data[7:0];
          CMD_PG_ON:        st_d.pgOn = cmd.data;
          CMD_TURN_ON_DELAY_TIME:    st_d.tonDly = cmd.data;
          CMD_TON_RAMP:     st_d.tonRamp = cmd.data;
          CMD_TURN_OFF_DELAY_TIME:   st_d.toffDly = cmd.data;
          CMD_TOFF_RAMP:    st_d.toffRamp = cmd.data;
          default: begin
            // Read-only or unknown code
            st_d.rsp.error = 1'b1;
            evt[SB_CML] = 1'b1;
          end
        endcase
      end else begin
        case (cmd.code)
          CMD_OV_WARN:     st_d.rsp.data = st_q.ovWarnLim;
          CMD_UV_WARN:     st_d.rsp.data = st_q.uvWarnLim;
          CMD_UV_FAULT:    st_d.rsp.data = st_q.uvFaultLim;
          CMD_UV_ACTION:   st_d.rsp.data = {8'h00, st_q.uvAction};
          CMD_PG_ON:       st_d.rsp.data = st_q.pgOn;
          CMD_TURN_ON_DELAY_TIME:   st_d.rsp.data = st_q.tonDly;
          CMD_TON_RAMP:    st_d.rsp.data = st_q.tonRamp;
          CMD_TURN_OFF_DELAY_TIME:  st_d.rsp.data = st_q.toffDly;
          CMD_TOFF_RAMP:   st_d.rsp.data = st_q.toffRamp;
          CMD_SUMMARY:     st_d.rsp.data = {8'h00, summaryOf(st_q)};
          CMD_STATUS_WORD: st_d.rsp.data = stWord;
          default: begin
            st_d.rsp.error = 1'b1;
            evt[SB_CML] = 1'b1;
          end
        endcase
      end
    end
    // Sticky flags: a set in the clearing cycle wins
    kept = clr ? 8'h00 : st_q.flags;
    st_d.flags  = kept | evt;
    st_d.flags[SB_OFF] = 1'b0;
    st_d.inWarn = (clr ? 2'b00 : st_q.inWarn) | {ovEvt, uvwEvt};
    st_d.alert  = (st_q.alert & !clr) | (|(evt & ~kept));
    // Fault response decode
    respCode = st_q.uvAction[RESP_HI:RESP_LO];
    retryCfg = st_q.uvAction[RETRY_HI:RETRY_LO];
    retryMs  = 16'(st_q.uvAction[TIME_HI:TIME_LO]) * RETRY_UNIT_MS;
    trig     = st_q.uvActive && (respCode != RESP_IGNORE);
    resumeOk = (retryCfg == RETRY_FOREVER) || (st_q.retriesLeft != 3'h0);
    afterOff = ((retryCfg != RETRY_NONE) && resumeOk) ? S_RETRY_WAIT : S_LATCHED;
    // Sequencer
    case (st_q.state)
      S_OFF: begin
        if (runEnable) begin
          st_d.state = S_ON_DELAY;
          st_d.retriesLeft = retryCfg;
        end
      end
      S_ON_DELAY, S_RISING, S_ON: begin
        if (!runEnable) begin
          st_d.state = (st_q.state == S_ON_DELAY) ? S_OFF : S_OFF_DELAY;
        end else if (trig) begin
          case (respCode)
            RESP_DELAY: st_d.state = S_FAULT_DELAY;
            RESP_NOW:   st_d.state = afterOff;
            default:    st_d.state = S_HOLD_OFF;
          endcase
        end else if (st_q.state == S_ON_DELAY) begin
          if (st_q.msCnt >= l11ToMs(st_q.tonDly)) st_d.state = S_RISING;
        end else if (st_q.state == S_RISING) begin
          if (st_q.msCnt >= l11ToMs(st_q.tonRamp)) st_d.state = S_ON;
        end
      end
      S_FAULT_DELAY: begin
        if (!runEnable) begin
          st_d.state = S_OFF_DELAY;
        end else if (st_q.msCnt >= retryMs) begin
          st_d.state = afterOff;
        end
      end
      S_RETRY_WAIT: begin
        if (!runEnable) begin
          st_d.state = S_OFF;
        end else if (st_q.msCnt >= retryMs) begin
          // Restart without looking at the fault
          st_d.state = S_ON_DELAY;
          if (retryCfg != RETRY_FOREVER) st_d.retriesLeft = st_q.retriesLeft - 3'h1;
        end
      end
      S_HOLD_OFF: begin
        if (!runEnable) st_d.state = S_OFF;
        else if (!st_q.uvActive) st_d.state = S_ON_DELAY;
      end
      S_LATCHED: begin
        if (!runEnable) st_d.state = S_OFF;
      end
      S_OFF_DELAY: begin
        if (st_q.msCnt >= l11ToMs(st_q.toffDly)) st_d.state = S_FALLING;
      end
      S_FALLING: begin
        if (st_q.msCnt >= l11ToMs(st_q.toffRamp)) st_d.state = S_OFF;
      end
      default: st_d.state = S_OFF;
    endcase
    // Time spent in the current state
    if (st_d.state != st_q.state) st_d.msCnt = 16'h0000;
    else if (tick && st_q.msCnt != 16'hffff) st_d.msCnt = st_q.msCnt + 16'h0001;
    // Rail outputs follow the next state
    st_d.railOn   = (st_d.state == S_RISING) || (st_d.state == S_ON) ||
                    (st_d.state == S_OFF_DELAY) || (st_d.state == S_FALLING) ||
                    (st_d.state == S_FAULT_DELAY); // Rail keeps running while delaying
    st_d.rampUp   = (st_d.state == S_RISING);
    st_d.rampDown = (st_d.state == S_FALLING);
    // Power good with hysteresis
    if (!st_d.railOn || voutMeas < outUvFaultThreshold) st_d.powerGood = 1'b0;
    else if (voutMeas > st_q.pgOn) st_d.powerGood = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q            <= '0;
      st_q.state      <= S_OFF;
      st_q.ovWarnLim  <= RST_OV_WARN;
      st_q.uvWarnLim  <= RST_UV_WARN;
      st_q.uvFaultLim <= RST_UV_FAULT;
      st_q.uvAction   <= RST_ACTION;
      st_q.tonDly     <= RST_DELAY;
      st_q.tonRamp    <= RST_RAMP;
      st_q.toffDly    <= RST_DELAY;
      st_q.toffRamp   <= RST_RAMP;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign rsp       = st_q.rsp;
  assign railOn    = st_q.railOn;
  assign rampUp    = st_q.rampUp;
  assign rampDown  = st_q.rampDown;
  assign powerGood = st_q.powerGood;
  assign alert     = st_q.alert;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ov_warn_set: assert property (ovEvt |=> st_q.inWarn[1] && st_q.flags[SB_UNLISTED])
    else $error("overvoltage warning not flagged");
  a_uv_hyst_hold: assert property (st_q.uvActive && !uvfEvt &&
    !(vinF > l11ToFix(st_q.uvWarnLim)) |=> st_q.uvActive)
    else $error("undervoltage fault released inside hysteresis");
  a_uv_warn_set: assert property (uvwEvt |=> st_q.inWarn[0] && st_q.flags[SB_UNLISTED])
    else $error("undervoltage warning not flagged");
  a_uv_declare: assert property (uvfEvt |=> st_q.uvActive && st_q.flags[SB_VIN_UV])
    else $error("undervoltage fault not declared");
  a_ignore_keep: assert property (st_q.state == S_ON && runEnable &&
    respCode == RESP_IGNORE |=> st_q.state == S_ON)
    else $error("ignored fault changed the rail");
  a_disable_now: assert property (st_q.state == S_ON && runEnable && st_q.uvActive &&
    respCode == RESP_NOW |=> !st_q.railOn)
    else $error("immediate disable missed");
  a_hold_off: assert property (st_q.state == S_HOLD_OFF && st_q.uvActive && runEnable
    |=> st_q.state == S_HOLD_OFF && !st_q.railOn)
    else $error("output left hold while fault present");
  a_flag_sticky: assert property (st_q.flags[SB_VIN_UV] && !clr |=> st_q.flags[SB_VIN_UV])
    else $error("fault flag dropped without clear");
  a_latch_stays: assert property (st_q.state == S_LATCHED && runEnable
    |=> st_q.state == S_LATCHED)
    else $error("latched rail restarted");
  a_pg_drop: assert property (voutMeas < outUvFaultThreshold |=> !st_q.powerGood)
    else $error("power good held below limit");
  a_word_low: assert property (cmd.valid && !cmd.write && cmd.code == CMD_STATUS_WORD
    |=> st_q.rsp.valid && st_q.rsp.data[7:0] == $past(summaryOf(st_q)))
    else $error("status word low byte differs");
  a_alert_hold: assert property (st_q.alert && !clr |=> st_q.alert)
    else $error("alert dropped without clear");

  // Fault response, retry and sequencing timing, write refusal and summary flag bits
  a_delay_enter: assert property (st_q.state == S_ON && runEnable && trig &&
    respCode == RESP_DELAY |=> st_q.state == S_FAULT_DELAY)
    else $error("delayed response not started");
  a_delay_wait: assert property (st_q.state == S_FAULT_DELAY && runEnable &&
    st_q.msCnt < retryMs |=> st_q.state == S_FAULT_DELAY && st_q.railOn)
    else $error("rail dropped inside response delay");
  a_hold_enter: assert property (st_q.state == S_ON && runEnable && trig &&
    respCode == RESP_HOLD |=> st_q.state == S_HOLD_OFF && !st_q.railOn)
    else $error("hold response not taken");
  a_no_retry: assert property (st_q.state == S_ON && runEnable && trig &&
    respCode == RESP_NOW && retryCfg == RETRY_NONE |=> st_q.state == S_LATCHED)
    else $error("no-retry fault did not latch");
  a_retry_count: assert property (st_q.state == S_RETRY_WAIT && runEnable &&
    st_q.msCnt >= retryMs && retryCfg != RETRY_FOREVER
    |=> st_q.retriesLeft == $past(st_q.retriesLeft) - 3'h1)
    else $error("retry count not spent");
  a_retry_restart: assert property (st_q.state == S_RETRY_WAIT && runEnable &&
    st_q.msCnt >= retryMs |=> st_q.state == S_ON_DELAY)
    else $error("retry did not restart");
  a_ton_wait: assert property (st_q.state == S_ON_DELAY && runEnable && !trig &&
    st_q.msCnt < l11ToMs(st_q.tonDly) |=> st_q.state == S_ON_DELAY && !st_q.railOn)
    else $error("rise started before turn-on delay");
  a_rise_ramp: assert property (st_q.state == S_RISING
    |-> st_q.rampUp && st_q.railOn)
    else $error("ramp up not shown while rising");
  a_toff_wait: assert property (st_q.state == S_OFF_DELAY &&
    st_q.msCnt < l11ToMs(st_q.toffDly) |=> st_q.state == S_OFF_DELAY && st_q.railOn)
    else $error("fall started before turn-off delay");
  a_fall_end: assert property (st_q.state == S_FALLING &&
    st_q.msCnt >= l11ToMs(st_q.toffRamp) |=> st_q.state == S_OFF && !st_q.railOn)
    else $error("rail not off after fall time");
  a_ro_refuse: assert property (cmd.valid && cmd.write && cmd.code == CMD_SUMMARY
    |=> st_q.rsp.error && st_q.flags[SB_CML])
    else $error("write to summary not refused");
  a_off_bit: assert property (cmd.valid && !cmd.write && cmd.code == CMD_SUMMARY
    |=> st_q.rsp.data[SB_OFF] == !$past(st_q.railOn))
    else $error("off bit does not follow rail");
  a_busy_flag: assert property (busyFault |=> st_q.flags[SB_BUSY])
    else $error("busy fault not flagged");
  a_temp_flag: assert property (tempFault |=> st_q.flags[SB_TEMP])
    else $error("temperature fault not flagged");
  a_unlisted: assert property (ovEvt || uvwEvt |=> st_q.flags[SB_UNLISTED])
    else $error("unlisted flag missing");

  c_rail_on:    cover property (st_q.state == S_RISING ##1 st_q.state == S_ON);
  c_retry:      cover property (st_q.state == S_RETRY_WAIT ##1 st_q.state == S_ON_DELAY);
  c_latched:    cover property (st_q.state == S_LATCHED);
  c_hold_clear: cover property (st_q.state == S_HOLD_OFF ##1 st_q.state == S_ON_DELAY);
  c_fault_delay: cover property (st_q.state == S_FAULT_DELAY ##1 st_q.state == S_LATCHED);

endmodule // ifss_top

// ### ifss_host.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Host side of the command port: one request per call
module ifss_host import ifss_pkg::*; (
  // Clock
  input  wire logic clk,
  // Command request
  output ifss_cmd_t cmd
);
  initial cmd = '0;

  // Hold the request through the taking edge, then release it with scrambled fields
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd <= '{valid: 1'b1, write: w, code: c, data: d};
    @(posedge clk);
    @(negedge clk);
    cmd <= '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
  endtask
endmodule // ifss_host

// ### input_fault_sequencing_status_bench.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module input_fault_sequencing_status_bench import ifss_pkg::*;;
  localparam logic [15:0] NOMV = 16'hd300;
  localparam logic [15:0] HYSV = 16'hca18;
  localparam logic [7:0]  REGS [11] = '{8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h60, 8'h61,
                                        8'h64, 8'h65, 8'h78, 8'h79};
  localparam logic [15:0] RSTV [11] = '{16'hd34d, 16'hca30, 16'hca00, 16'h0080, 16'h0900,
                                        16'hca80, 16'hd280, 16'hca80, 16'hd280, 16'h0040,
                                        16'h0840};
  localparam logic [7:0]  SRCB [5] = '{8'h80, 8'h20, 8'h10, 8'h04, 8'h02};
  localparam logic [7:0]  ACT [6]  = '{8'h00, 8'h80, 8'hc0, 8'h41, 8'h89, 8'hb8};
  localparam logic [2:0]  EXPR [6] = '{3'b111, 3'b000, 3'b001, 3'b100, 3'b000, 3'b001};
  logic        clk = 1'b0;
  logic        rst_n;
  logic        runEnable;
  logic [4:0]  src;
  logic [15:0] vinMeas;
  logic [15:0] voutMeas;
  logic [7:0]  acc;
  logic [15:0] rv;
  ifss_cmd_t   cmd;
  ifss_rsp_t   rsp;
  logic        railOn, rampUp, rampDown, powerGood, alert;
  logic [16:0] expQ [$];
  int          fails = 0;
  int          samples_checked = 0;
  int          seed = 32'h30d7bcb7;

  // Clock
  always #2 clk = ~clk;

  ifss_host host (.clk(clk), .cmd(cmd));

  ifss_top #(.MS_CYCLES_P(4)) uut (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .vinMeas(vinMeas), .voutMeas(voutMeas),
    .outUvFaultThreshold(16'h0400), .voutStrap(16'h0a00), .runEnable(runEnable),
    .busyFault(src[0]), .voutOvFault(src[1]), .ioutOcFault(src[2]), .tempFault(src[3]),
    .cmlFault(src[4]), .railOn(railOn), .rampUp(rampUp), .rampDown(rampDown),
    .powerGood(powerGood), .alert(alert)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Value compare
  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Duration compare: cycles until a rail output reaches a level
  task automatic span(input int sel, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while ((sel == 0 ? railOn : sel == 1 ? rampUp : rampDown) !== v && n < 2000) begin
      @(negedge clk);
      n++;
    end
    samples_checked++;
    if (n < lo || n > hi) begin
      fails++;
      $display("wrong value at %0t: output %0d took %0d cycles", $time, sel, n);
    end
  endtask

  // Note the expected answer, then issue the command
  task automatic cmdOp(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic [16:0] e);
    expQ.push_back(e);
    host.xfer(w, c, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Response watcher: oldest note against each answer
  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      if (expQ.size() == 0) check(17'h1ffff, 17'h0, "unexpected response");
      else check({rsp.error, rsp.data}, expQ.pop_front(), "response");
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    runEnable = 1'b0;
    src = 5'h00;
    vinMeas = NOMV;
    voutMeas = 16'h0000;
    repeat (3) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    idle(2);
    check({railOn, rampUp, rampDown, powerGood, alert}, 17'h0, "outputs after reset");
    foreach (REGS[i]) cmdOp(1'b0, REGS[i], 16'h0, {1'b0, RSTV[i]});
    $display("test reset values done");

    repeat (4) begin
      rv = 16'($random(seed));
      cmdOp(1'b1, 8'h5a, rv, 17'h0);
      cmdOp(1'b0, 8'h5a, 16'h0, {9'h0, rv[7:0]});
      cmdOp(1'b1, 8'h59, rv, 17'h0);
      cmdOp(1'b0, 8'h59, 16'h0, {1'b0, rv});
    end
    cmdOp(1'b1, 8'h59, 16'hca00, 17'h0);
    cmdOp(1'b1, 8'h03, 16'h0, 17'h0);
    cmdOp(1'b1, 8'h78, 16'h00ff, 17'h10000);
    idle(3);
    cmdOp(1'b0, 8'h78, 16'h0, 17'h0042);
    check(alert, 1'b1, "alert after refusal");
    cmdOp(1'b1, 8'h03, 16'h0, 17'h0);
    idle(3);
    cmdOp(1'b0, 8'h78, 16'h0, 17'h0040);
    check(alert, 1'b0, "alert after clear");
    acc = 8'h40;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk) src[i] = 1'b1;
      @(negedge clk) src[i] = 1'b0;
      idle(3);
      acc = acc | SRCB[i];
      cmdOp(1'b0, 8'h78, 16'h0, {9'h0, acc});
    end
    cmdOp(1'b1, 8'h03, 16'h0, 17'h0);
    $display("test refusal and summary bits done");

    vinMeas = 16'hd3ff;
    idle(3);
    cmdOp(1'b0, 8'h79, 16'h0, 17'h2841);
    check(alert, 1'b1, "alert on overvoltage warning");
    vinMeas = HYSV;
    cmdOp(1'b1, 8'h03, 16'h0, 17'h0);
    idle(3);
    cmdOp(1'b0, 8'h79, 16'h0, 17'h2841);
    vinMeas = NOMV;
    cmdOp(1'b1, 8'h03, 16'h0, 17'h0);
    $display("test input warnings done");

    cmdOp(1'b1, 8'h60, 16'h0002, 17'h0);
    cmdOp(1'b1, 8'h61, 16'h0003, 17'h0);
    cmdOp(1'b1, 8'h64, 16'h0001, 17'h0);
    cmdOp(1'b1, 8'h65, 16'h0002, 17'h0);
    voutMeas = 16'h0a00;
    @(negedge clk) runEnable = 1'b1;
    span(0, 1'b1, 7, 10);
    check(rampUp, 1'b1, "ramp starts");
    span(1, 1'b0, 11, 18);
    idle(2);
    check(powerGood, 1'b1, "power good on");
    voutMeas = 16'h0100;
    idle(3);
    check(powerGood, 1'b0, "power good off");
    voutMeas = 16'h0800;
    idle(3);
    check(powerGood, 1'b0, "power good held");
    voutMeas = 16'h0a00;
    @(negedge clk) runEnable = 1'b0;
    span(2, 1'b1, 3, 6);
    check(railOn, 1'b1, "rail held in off delay");
    span(2, 1'b0, 7, 14);
    check(railOn, 1'b0, "rail off after fall");
    $display("test sequencing done");

    foreach (ACT[i]) begin
      @(negedge clk) runEnable = 1'b0;
      idle(60);
      cmdOp(1'b1, 8'h5a, {8'h00, ACT[i]}, 17'h0);
      cmdOp(1'b1, 8'h03, 16'h0, 17'h0);
      @(negedge clk) runEnable = 1'b1;
      idle(60);
      check(railOn, 1'b1, "rail up");
      vinMeas = 16'hc800;
      idle(30);
      check(railOn, EXPR[i][2], "after drop");
      vinMeas = HYSV;
      idle(60);
      check(railOn, EXPR[i][1], "in hysteresis");
      vinMeas = NOMV;
      idle(120);
      check(railOn, EXPR[i][0], "after recovery");
      cmdOp(1'b0, 8'h78, 16'h0, {9'h0, (EXPR[i][0] ? 8'h09 : 8'h49)});
    end
    $display("test undervoltage actions done");

    idle(4);
    check(17'(expQ.size()), 17'h0, "answers missing");
    wrap_up();
  end
endmodule // input_fault_sequencing_status_bench
